// ---- design/dacsi_pkg.sv ----
/*
 package for the serial input of the 12-bit voltage DAC: widths, reset values, frame carrier.
 assumes the link clock and data are sampled by a faster system clock.
*/
package dacsi_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int MODE_W = 2;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
  localparam int CODE_LSB = 0;
  localparam int MODE_LSB = 12;
  localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [CODE_W-1:0] code;
  } dacsi_conv_t;
endpackage

// ---- design/dacsi_top.sv ----
/*
 serial write port of the 12-bit DAC: shift register, frame control, converter register.
 assumes select, link clock and data come from pins outside the clk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dacsi_top (
  // system
  input wire logic clk_i,
  input wire logic reset_n_i,
  // serial link
  input wire logic frame_select_n_i,
  input wire logic shift_clock_i,
  input wire logic serial_data_in_i,
  // converter side
  output logic [dacsi_pkg::CODE_W-1:0] analog_output_o,
  output logic power_down_o,
  output logic [dacsi_pkg::MODE_W-1:0] power_mode_o,
  output logic update_o
);
  logic [2:0] sel_s;
  logic [2:0] sck_s;
  logic [1:0] sdi_s;
  logic [dacsi_pkg::WORD_W-1:0] shift;
  logic [dacsi_pkg::CNT_W-1:0] count;
  logic active;
  dacsi_pkg::dacsi_conv_t conv;
  logic written;

  // synchronisers; stage 0 read only by stage 1
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sel_s <= 3'h7;
      sck_s <= 3'h7;
      sdi_s <= 2'h0;
    end else begin
      sel_s <= {sel_s[1:0], frame_select_n_i};
      sck_s <= {sck_s[1:0], shift_clock_i};
      sdi_s <= {sdi_s[0], serial_data_in_i};
    end
  end

  wire sel_low = !sel_s[1];
  wire sel_fall = sel_s[2] && !sel_s[1];
  wire sck_fall = sck_s[2] && !sck_s[1] && sel_low;
  wire last_bit = (count == dacsi_pkg::FRAME_BITS - 5'h01);
  wire [dacsi_pkg::WORD_W-1:0] next_shift = {shift[dacsi_pkg::WORD_W-2:0], sdi_s[1]};

  // frame tracking
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      active <= 1'b0;
      count <= dacsi_pkg::CNT_RST;
    end else if (!sel_low) begin
      active <= 1'b0;
      count <= dacsi_pkg::CNT_RST;
    end else if (sel_fall) begin
      active <= 1'b1;
      count <= dacsi_pkg::CNT_RST;
    end else if (active && sck_fall) begin
      count <= count + 5'h01;
      if (last_bit) begin
        active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shift <= dacsi_pkg::SHIFT_RST;
    end else if (active && sck_fall) begin
      shift <= next_shift;
    end
  end

  // converter register, zero until first full frame
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      conv <= '{mode: dacsi_pkg::MODE_RST, code: dacsi_pkg::CODE_RST};
      written <= 1'b0;
      update_o <= 1'b0;
    end else begin
      update_o <= 1'b0;
      if (active && sck_fall && last_bit && sel_low) begin
        conv.code <= next_shift[dacsi_pkg::CODE_LSB +: dacsi_pkg::CODE_W];
        conv.mode <= next_shift[dacsi_pkg::MODE_LSB +: dacsi_pkg::MODE_W];
        written <= 1'b1;
        update_o <= 1'b1;
      end
    end
  end

  // mode decode shared by outputs and checks
  function automatic logic mode_is_normal(input logic [dacsi_pkg::MODE_W-1:0] mode);
    return mode == dacsi_pkg::MODE_NORMAL;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      analog_output_o <= dacsi_pkg::CODE_RST;
      power_down_o <= 1'b0;
      power_mode_o <= dacsi_pkg::MODE_RST;
    end else begin
      power_mode_o <= conv.mode;
      power_down_o <= written && !mode_is_normal(conv.mode);
      analog_output_o <= (written && mode_is_normal(conv.mode)) ? conv.code : dacsi_pkg::CODE_RST;
    end
  end

  // assertions
  property p_shift_on_fall;
    @(posedge clk_i) disable iff (!reset_n_i) (active && sck_fall) |=> (shift[0] == $past(sdi_s[1]));
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall) else $error("bit not shifted");

  property p_count_step;
    @(posedge clk_i) disable iff (!reset_n_i) (active && sck_fall) |=> (count == $past(count) + 5'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("bit count did not advance");

  property p_frame_start;
    @(posedge clk_i) disable iff (!reset_n_i) (sel_fall) |=> (active && count == dacsi_pkg::CNT_RST);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not started");

  property p_fall_from_idle;
    @(posedge clk_i) disable iff (!reset_n_i) sel_fall |-> !active;
  endproperty
  a_fall_from_idle: assert property (p_fall_from_idle) else $error("frame start while shifting");

  property p_update_16;
    @(posedge clk_i) disable iff (!reset_n_i) update_o |-> ($past(count) == dacsi_pkg::FRAME_BITS - 5'h01);
  endproperty
  a_update_16: assert property (p_update_16) else $error("update not on 16th edge");

  property p_update_once;
    @(posedge clk_i) disable iff (!reset_n_i) update_o |=> !update_o;
  endproperty
  a_update_once: assert property (p_update_once) else $error("update longer than one cycle");

  property p_last_stops;
    @(posedge clk_i) disable iff (!reset_n_i) (active && sck_fall && last_bit) |=> !active;
  endproperty
  a_last_stops: assert property (p_last_stops) else $error("shifting went on after last bit");

  property p_count_bound;
    @(posedge clk_i) disable iff (!reset_n_i) active |-> (count < dacsi_pkg::FRAME_BITS);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("bit count past frame length");

  property p_update_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      update_o |=> (!mode_is_normal(power_mode_o) || analog_output_o == conv.code);
  endproperty
  a_update_code: assert property (p_update_code) else $error("output not updated");

  property p_abort;
    @(posedge clk_i) disable iff (!reset_n_i) (!sel_low) |=> (!update_o && !active && count == dacsi_pkg::CNT_RST);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");

  property p_conv_hold;
    @(posedge clk_i) disable iff (!reset_n_i) $changed(conv) |-> update_o;
  endproperty
  a_conv_hold: assert property (p_conv_hold) else $error("converter register changed without update");

  property p_out_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      $changed({analog_output_o, power_down_o, power_mode_o}) |-> $past(update_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output changed without update");

  property p_zero;
    @(posedge clk_i) disable iff (!reset_n_i) (!written) |=> (analog_output_o == dacsi_pkg::CODE_RST);
  endproperty
  a_zero: assert property (p_zero) else $error("output not zero before write");

  property p_zero_before_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!written) |-> (analog_output_o == dacsi_pkg::CODE_RST && !power_down_o);
  endproperty
  a_zero_before_write: assert property (p_zero_before_write) else $error("outputs active before write");

  property p_written_holds;
    @(posedge clk_i) disable iff (!reset_n_i) written |=> written;
  endproperty
  a_written_holds: assert property (p_written_holds) else $error("write flag lost");

  property p_update_written;
    @(posedge clk_i) disable iff (!reset_n_i) update_o |-> written;
  endproperty
  a_update_written: assert property (p_update_written) else $error("update without write flag");

  property p_first_write;
    @(posedge clk_i) disable iff (!reset_n_i) $rose(written) |-> update_o;
  endproperty
  a_first_write: assert property (p_first_write) else $error("write flag set without update");

  property p_pd;
    @(posedge clk_i) disable iff (!reset_n_i) $rose(power_down_o) |-> (analog_output_o == dacsi_pkg::CODE_RST);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down output not zero");

  property p_pd_zero;
    @(posedge clk_i) disable iff (!reset_n_i) power_down_o |-> (analog_output_o == dacsi_pkg::CODE_RST);
  endproperty
  a_pd_zero: assert property (p_pd_zero) else $error("output live in power-down");

  property p_pd_mode;
    @(posedge clk_i) disable iff (!reset_n_i) power_down_o == !mode_is_normal(power_mode_o);
  endproperty
  a_pd_mode: assert property (p_pd_mode) else $error("power-down does not match mode");

  property p_update_mode;
    @(posedge clk_i) disable iff (!reset_n_i) update_o |=> (power_mode_o == conv.mode);
  endproperty
  a_update_mode: assert property (p_update_mode) else $error("mode not updated");

  property p_idle;
    @(posedge clk_i) disable iff (!reset_n_i) (!sel_low && $stable(sel_s[1])) |=> $stable(shift);
  endproperty
  a_idle: assert property (p_idle) else $error("shift while idle");

  property p_no_shift_idle;
    @(posedge clk_i) disable iff (!reset_n_i) (!active) |=> $stable(shift);
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift outside frame");

  c_update: cover property (@(posedge clk_i) disable iff (!reset_n_i) update_o);
  c_abort: cover property (@(posedge clk_i) disable iff (!reset_n_i) active && !sel_low);
  c_pd: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(power_down_o));
  c_pd_exit: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(power_down_o));
  c_idle_clock: cover property (@(posedge clk_i) disable iff (!reset_n_i) !sel_low && sck_s[2] && !sck_s[1]);
endmodule
`default_nettype wire

// ---- verif/dacsi_host.sv ----
/*
 host model: writes frames into the dac serial port.
 assumes clk_i at 100 MHz; link clock 80 ns, runs only in frames or idle bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module dacsi_host (
  // system
  input wire logic clk_i,
  // serial link
  output logic frame_select_n_o,
  output logic shift_clock_o,
  output logic serial_data_o
);
  initial begin
    frame_select_n_o = 1'b1;
    shift_clock_o = 1'b1;
    serial_data_o = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    frame_select_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 15; i > 15 - n; i--) begin
      shift_clock_o <= 1'b1;
      serial_data_o <= w[i];
      repeat (4) @(posedge clk_i);
      shift_clock_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    shift_clock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    frame_select_n_o <= 1'b1;
    // released data line shows no stale bit
    serial_data_o <= ~serial_data_o;
    repeat (4) @(posedge clk_i);
  endtask
  // link clock pulses with select high, to be ignored
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      shift_clock_o <= 1'b0;
      serial_data_o <= ~serial_data_o;
      repeat (4) @(posedge clk_i);
      shift_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/dacsi_top_bench.sv ----
/*
 bench for the dac serial port: host model drives, queue of notes checks.
 assumes dacsi_pkg and dacsi_top are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module dacsi_top_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  wire logic sel_n, sclk, sdi;
  logic [dacsi_pkg::CODE_W-1:0] analog_output_o, last_out;
  logic [dacsi_pkg::MODE_W-1:0] power_mode_o;
  logic power_down_o, update_o;
  logic [15:0] w;
  dacsi_pkg::dacsi_conv_t exp_q[$];
  dacsi_pkg::dacsi_conv_t cur;
  int checked = 0, mismatches = 0, cycles = 0, seed;
  always #5 clk_i = ~clk_i;
  dacsi_host host (.clk_i(clk_i), .frame_select_n_o(sel_n), .shift_clock_o(sclk), .serial_data_o(sdi));
  dacsi_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .frame_select_n_i(sel_n), .shift_clock_i(sclk),
    .serial_data_in_i(sdi), .analog_output_o(analog_output_o), .power_down_o(power_down_o),
    .power_mode_o(power_mode_o), .update_o(update_o));
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  always @(negedge clk_i) begin
    if (update_o === 1'b1) begin
      if (exp_q.size() == 0) `CHK(update_o, 1'b0)
      else begin
        cur = exp_q.pop_front();
        @(posedge clk_i);
        #1;
        `CHK(power_mode_o, cur.mode)
        `CHK(power_down_o, cur.mode != dacsi_pkg::MODE_NORMAL)
        `CHK(analog_output_o, (cur.mode == dacsi_pkg::MODE_NORMAL) ? cur.code : dacsi_pkg::CODE_RST)
      end
    end
  end
  initial begin
    seed = 32'h439c;
    last_out = dacsi_pkg::CODE_RST;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(analog_output_o, dacsi_pkg::CODE_RST)
    @(posedge clk_i);
    for (int m = 0; m < 5; m++) begin
      w = $random(seed);
      w[13:12] = m[1:0];
      if (m == 1) begin
        host.send(~w, 15);
        host.idle(3);
        #1;
        `CHK(analog_output_o, last_out)
        `CHK(power_down_o, 1'b0)
        @(posedge clk_i);
      end
      exp_q.push_back(dacsi_pkg::dacsi_conv_t'(w[13:0]));
      host.send(w, 16);
      last_out = (w[13:12] == dacsi_pkg::MODE_NORMAL) ? w[11:0] : dacsi_pkg::CODE_RST;
    end
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(analog_output_o, dacsi_pkg::CODE_RST)
    `CHK(power_down_o, 1'b0)
    @(posedge clk_i);
    w = $random(seed);
    w[13:12] = dacsi_pkg::MODE_NORMAL;
    exp_q.push_back(dacsi_pkg::dacsi_conv_t'(w[13:0]));
    host.send(w, 16);
    repeat (10) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
`default_nettype wire
